// [pwm_group_pkg.sv]
// Shared constants, types and helpers for the three-channel PWM group.
// Assumes one 50 MHz operation clock that also serves as the count clock.
package pwm_group_pkg;

	// Counter geometry
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_RESET = 16'hFFFF;

	// Channel placement: master index and its two consecutive slaves
	localparam int MASTER_CH = 0;
	localparam int SLAVE1_CH = MASTER_CH + 1;
	localparam int SLAVE2_CH = MASTER_CH + 2;

	// Bit positions inside the two-bit slave vectors
	localparam int SLAVE1_BIT = 0;
	localparam int SLAVE2_BIT = 1;

	// Reset values
	localparam logic ENABLE_RESET = 1'b0;
	localparam logic OUT_VALUE_RESET = 1'b0;
	localparam logic IRQ_RESET = 1'b0;
	localparam logic PORT_MODE_RESET = 1'b1;

	// Polarity encoding
	localparam logic POL_ACTIVE_HIGH = 1'b0;

	// Timing
	localparam real CLK_PERIOD_NS = 20.0;
	localparam int OUT_ACTIVE_DELAY_CYCLES = 1;

	// Slave counting state
	typedef enum logic {
		SL_IDLE = 1'b0,
		SL_COUNT = 1'b1
	} slave_state_t;

	// One down-count step
	function automatic logic [15:0] down_step(input logic [15:0] cnt);
		down_step = cnt - CNT_ONE;
	endfunction

	// Active and inactive pin level for a polarity bit
	function automatic logic active_level(input logic pol);
		active_level = (pol == POL_ACTIVE_HIGH);
	endfunction

endpackage

// [one_count_slave.sv]
// One-count slave channel: reloads its duty on the master's period event,
// holds its output active for duty+1 count clocks, then halts.
// Assumes the trigger is a one-cycle pulse from the master channel.
`timescale 1ns/10ps
module one_count_slave (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clear,
	input wire logic run,
	input wire logic trigger,
	input wire logic [pwm_group_pkg::CNT_W-1:0] duty_value,
	input wire logic polarity,
	input wire logic output_enable,
	input wire logic value_write,
	input wire logic value_wdata,
	output logic [pwm_group_pkg::CNT_W-1:0] down_counter,
	output logic pwm_output
);
	import pwm_group_pkg::*;

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	slave_state_t state_r;
	slave_state_t state_nxt;
	logic out_r;
	logic out_nxt;

	// Next counter, state and output level
	always_comb begin
		cnt_nxt = cnt_r;
		state_nxt = state_r;
		out_nxt = out_r;
		if (clear) begin
			cnt_nxt = CNT_RESET;
			state_nxt = SL_IDLE;
			out_nxt = OUT_VALUE_RESET;
		end else begin
			if (run && trigger) begin
				cnt_nxt = duty_value;
				state_nxt = SL_COUNT;
				if (output_enable) begin
					out_nxt = active_level(polarity);
				end
			end else if (run && state_r == SL_COUNT) begin
				if (cnt_r == CNT_ZERO) begin
					state_nxt = SL_IDLE;
					if (output_enable) begin
						out_nxt = ~active_level(polarity);
					end
				end else begin
					cnt_nxt = down_step(cnt_r);
				end
			end
			// Software level only reaches the pin while counting is kept off it
			if (!output_enable && value_write) begin
				out_nxt = value_wdata;
			end
		end
	end

	// Register stage
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= CNT_RESET;
			state_r <= SL_IDLE;
			out_r <= OUT_VALUE_RESET;
		end else begin
			cnt_r <= cnt_nxt;
			state_r <= state_nxt;
			out_r <= out_nxt;
		end
	end

	assign down_counter = cnt_r;
	assign pwm_output = out_r;

endmodule // one_count_slave

// [multi_pwm_channel_group.sv]
// Three-channel PWM group: one interval master sets the period, two
// one-count slaves set the duty of two PWM pins.
// Assumes all control inputs are synchronous to ref_clk and that each
// trigger input is a one-cycle write pulse from software.
`timescale 1ns/10ps
// Functional notes
// - Starting all three triggers together sets all three enable flags.
// - Start triggers are one-shot pulses that hold no state.
// - Master raises its period event as soon as it starts counting.
// - Every master period event restarts each slave channel that is enabled and not being stopped.
// - All three counters are readable at any time.
// - Per-channel status registers play no part here.
// - Master loads the period value and counts down once per clock.
// - At zero the master raises its event and reloads in that cycle.
// - On each master event slave 1 loads its duty and counts down.
// - Slave 1 goes active one clock after the event, inactive at zero.
// - On each master event slave 2 loads its duty and counts down.
// - Slave 2 goes active one clock after the event, inactive at zero.
// - Period and duty cycles repeat until the group is stopped.
// - Stop triggers written together are one-shot pulses.
// - Stop clears the enable flags and freezes every counter.
// - Stop leaves the slave output levels as they were.
// - With output enable low the pin follows the written output value.
// - Unit power off clears all state, output values and selects port mode.
// - Polarity 0 gives active-high output, 1 gives active-low output.
// - Output enable 0 keeps counting off the pin, 1 lets it drive.
module multi_pwm_channel_group (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic timer_unit_power_enable,
	input wire logic master_start_trigger,
	input wire logic slave1_start_trigger,
	input wire logic slave2_start_trigger,
	input wire logic master_stop_trigger,
	input wire logic slave1_stop_trigger,
	input wire logic slave2_stop_trigger,
	input wire logic [pwm_group_pkg::CNT_W-1:0] master_period_value,
	input wire logic [pwm_group_pkg::CNT_W-1:0] slave1_duty_value,
	input wire logic [pwm_group_pkg::CNT_W-1:0] slave2_duty_value,
	input wire logic [1:0] output_polarity_select,
	input wire logic slave1_output_enable,
	input wire logic slave2_output_enable,
	input wire logic output_value_write,
	input wire logic [1:0] output_value_wdata,
	output logic master_enable_status,
	output logic slave1_enable_status,
	output logic slave2_enable_status,
	output logic [pwm_group_pkg::CNT_W-1:0] master_down_counter,
	output logic [pwm_group_pkg::CNT_W-1:0] slave1_down_counter,
	output logic [pwm_group_pkg::CNT_W-1:0] slave2_down_counter,
	output logic master_period_irq,
	output logic slave1_pwm_output,
	output logic slave2_pwm_output,
	output logic pin_port_mode
);
	import pwm_group_pkg::*;

	logic [2:0] en_r;
	logic [2:0] en_nxt;
	logic [2:0] start_trig;
	logic [2:0] stop_trig;
	logic [CNT_W-1:0] mcnt_r;
	logic [CNT_W-1:0] mcnt_nxt;
	logic irq_r;
	logic irq_nxt;
	logic port_mode_r;
	logic port_mode_nxt;
	logic clear;
	logic master_run;
	logic slave1_run;
	logic slave2_run;

	// Trigger pulses act only in the cycle they arrive; nothing stores them
	assign start_trig = {slave2_start_trigger, slave1_start_trigger, master_start_trigger};
	assign stop_trig = {slave2_stop_trigger, slave1_stop_trigger, master_stop_trigger};
	assign clear = !timer_unit_power_enable;

	// A channel counts only while enabled (a slave also in its start cycle) and not being stopped this cycle
	assign master_run = en_r[0] && !stop_trig[0] && !clear;
	assign slave1_run = (en_r[1] || start_trig[1]) && !stop_trig[1] && !clear;
	assign slave2_run = (en_r[2] || start_trig[2]) && !stop_trig[2] && !clear;

	// Enable flags, port mode, master counter and period event
	always_comb begin
		en_nxt = en_r;
		mcnt_nxt = mcnt_r;
		irq_nxt = 1'b0;
		port_mode_nxt = 1'b0;
		if (clear) begin
			en_nxt = {3{ENABLE_RESET}};
			mcnt_nxt = CNT_RESET;
			port_mode_nxt = PORT_MODE_RESET;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (start_trig[i]) begin
					en_nxt[i] = 1'b1;
				end else if (stop_trig[i]) begin
					en_nxt[i] = 1'b0;
				end
			end
			if (start_trig[0]) begin
				mcnt_nxt = master_period_value;
				irq_nxt = 1'b1;
			end else if (master_run) begin
				if (mcnt_r == CNT_ZERO) begin
					mcnt_nxt = master_period_value;
					irq_nxt = 1'b1;
				end else begin
					mcnt_nxt = down_step(mcnt_r);
				end
			end
		end
	end

	// Register stage for the master side
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			en_r <= {3{ENABLE_RESET}};
			mcnt_r <= CNT_RESET;
			irq_r <= IRQ_RESET;
			port_mode_r <= PORT_MODE_RESET;
		end else begin
			en_r <= en_nxt;
			mcnt_r <= mcnt_nxt;
			irq_r <= irq_nxt;
			port_mode_r <= port_mode_nxt;
		end
	end

	// Enabled slave channels not being stopped restart on every master period event
	one_count_slave u_slave1 (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clear(clear),
		.run(slave1_run),
		.trigger(irq_r),
		.duty_value(slave1_duty_value),
		.polarity(output_polarity_select[SLAVE1_BIT]),
		.output_enable(slave1_output_enable),
		.value_write(output_value_write),
		.value_wdata(output_value_wdata[SLAVE1_BIT]),
		.down_counter(slave1_down_counter),
		.pwm_output(slave1_pwm_output)
	);

	one_count_slave u_slave2 (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clear(clear),
		.run(slave2_run),
		.trigger(irq_r),
		.duty_value(slave2_duty_value),
		.polarity(output_polarity_select[SLAVE2_BIT]),
		.output_enable(slave2_output_enable),
		.value_write(output_value_write),
		.value_wdata(output_value_wdata[SLAVE2_BIT]),
		.down_counter(slave2_down_counter),
		.pwm_output(slave2_pwm_output)
	);

	// Status and counters straight from flip-flops; no per-channel status kept
	assign master_enable_status = en_r[0];
	assign slave1_enable_status = en_r[1];
	assign slave2_enable_status = en_r[2];
	assign master_down_counter = mcnt_r;
	assign master_period_irq = irq_r;
	assign pin_port_mode = port_mode_r;

	// Checks on the group behaviour
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	property p_start_enables;
		timer_unit_power_enable && master_start_trigger && slave1_start_trigger
			&& slave2_start_trigger
		|=> master_enable_status && slave1_enable_status && slave2_enable_status;
	endproperty
	a_start_enables: assert property (p_start_enables)
		else $error("start did not set all enable flags");

	property p_irq_at_start;
		timer_unit_power_enable && master_start_trigger
		|=> master_period_irq && master_down_counter == $past(master_period_value);
	endproperty
	a_irq_at_start: assert property (p_irq_at_start)
		else $error("no period event or load at master start");

	property p_master_reload;
		timer_unit_power_enable && master_enable_status && !master_stop_trigger
			&& !master_start_trigger && master_down_counter == CNT_ZERO
		|=> master_period_irq && master_down_counter == $past(master_period_value);
	endproperty
	a_master_reload: assert property (p_master_reload)
		else $error("master did not reload at zero");

	property p_master_decrement;
		timer_unit_power_enable && master_enable_status && !master_stop_trigger
			&& !master_start_trigger && master_down_counter != CNT_ZERO
		|=> !master_period_irq && master_down_counter == down_step($past(master_down_counter));
	endproperty
	a_master_decrement: assert property (p_master_decrement)
		else $error("master counter did not step down by one");

	property p_slave1_load;
		timer_unit_power_enable && master_period_irq && slave1_enable_status
			&& !slave1_stop_trigger && slave1_output_enable && !output_value_write
		|=> slave1_down_counter == $past(slave1_duty_value)
			&& slave1_pwm_output == active_level($past(output_polarity_select[SLAVE1_BIT]));
	endproperty
	a_slave1_load: assert property (p_slave1_load)
		else $error("slave 1 did not load duty and go active");

	property p_slave2_load;
		timer_unit_power_enable && master_period_irq && slave2_enable_status
			&& !slave2_stop_trigger && slave2_output_enable && !output_value_write
		|=> slave2_down_counter == $past(slave2_duty_value)
			&& slave2_pwm_output == active_level($past(output_polarity_select[SLAVE2_BIT]));
	endproperty
	a_slave2_load: assert property (p_slave2_load)
		else $error("slave 2 did not load duty and go active");

	property p_stop_freezes;
		timer_unit_power_enable && master_stop_trigger && !master_start_trigger
		|=> !master_enable_status && !master_period_irq
			&& master_down_counter == $past(master_down_counter);
	endproperty
	a_stop_freezes: assert property (p_stop_freezes)
		else $error("master stop did not freeze the counter");

	property p_stop_holds_output;
		timer_unit_power_enable && slave1_stop_trigger && !slave1_start_trigger
			&& !output_value_write
		|=> $stable(slave1_pwm_output);
	endproperty
	a_stop_holds_output: assert property (p_stop_holds_output)
		else $error("slave 1 output changed on stop");

	property p_direct_value;
		timer_unit_power_enable && !slave2_output_enable && output_value_write
		|=> slave2_pwm_output == $past(output_value_wdata[SLAVE2_BIT]);
	endproperty
	a_direct_value: assert property (p_direct_value)
		else $error("slave 2 pin did not follow written value");

	property p_power_off;
		!timer_unit_power_enable
		|=> pin_port_mode && !slave1_pwm_output && !slave2_pwm_output
			&& !master_enable_status && !slave1_enable_status && !slave2_enable_status;
	endproperty
	a_power_off: assert property (p_power_off)
		else $error("power off did not clear the group");

	property p_oe_blocks_counting;
		timer_unit_power_enable && !slave1_output_enable && !output_value_write
		|=> $stable(slave1_pwm_output);
	endproperty
	a_oe_blocks_counting: assert property (p_oe_blocks_counting)
		else $error("counting changed slave 1 output with enable low");

	// A step from one to zero can only happen while the slave is counting
	property p_slave1_end;
		timer_unit_power_enable && slave1_enable_status && !slave1_stop_trigger
			&& !master_period_irq && slave1_output_enable && !output_value_write
			&& slave1_down_counter == CNT_ZERO && $past(slave1_down_counter) == CNT_ONE
		|=> slave1_pwm_output == !active_level($past(output_polarity_select[SLAVE1_BIT]));
	endproperty
	a_slave1_end: assert property (p_slave1_end)
		else $error("slave 1 did not go inactive at zero");

	property p_slave2_end;
		timer_unit_power_enable && slave2_enable_status && !slave2_stop_trigger
			&& !master_period_irq && slave2_output_enable && !output_value_write
			&& slave2_down_counter == CNT_ZERO && $past(slave2_down_counter) == CNT_ONE
		|=> slave2_pwm_output == !active_level($past(output_polarity_select[SLAVE2_BIT]));
	endproperty
	a_slave2_end: assert property (p_slave2_end)
		else $error("slave 2 did not go inactive at zero");

	property p_slave_stop_freezes;
		timer_unit_power_enable && slave1_stop_trigger && slave2_stop_trigger
			&& !slave1_start_trigger && !slave2_start_trigger
		|=> $stable(slave1_down_counter) && $stable(slave2_down_counter);
	endproperty
	a_slave_stop_freezes: assert property (p_slave_stop_freezes)
		else $error("slave counters moved on stop");

	property p_idle_no_irq;
		timer_unit_power_enable && !master_enable_status && !master_start_trigger
		|=> !master_period_irq;
	endproperty
	a_idle_no_irq: assert property (p_idle_no_irq)
		else $error("period event while master stopped");

	// Main scenarios
	c_start: cover property (master_start_trigger && slave1_start_trigger ##1 master_period_irq);
	c_reload: cover property (master_enable_status && master_down_counter == CNT_ZERO
		##1 master_period_irq);
	c_pulse: cover property ($rose(slave1_pwm_output) ##[1:20] $fell(slave1_pwm_output));
	c_stop: cover property (master_enable_status && master_stop_trigger
		##1 !master_enable_status);
	c_power_cycle: cover property (!timer_unit_power_enable ##[1:20] master_start_trigger);

endmodule // multi_pwm_channel_group

// [pwm_load_model.sv]
// Model of the external loads on the two PWM pins: records active pulse widths.
// Assumes the pins change only just after rising edges of ref_clk.
`timescale 1ns/10ps
module pwm_load_model (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [1:0] pins,
	input wire logic [1:0] active_level,
	output logic [15:0] width1,
	output logic [15:0] width2
);
	logic [15:0] run_r [2];
	logic [15:0] last_r [2];

	// Count active cycles and latch the count when a pin leaves its active level
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			run_r <= '{16'h0000, 16'h0000};
			last_r <= '{16'h0000, 16'h0000};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (pins[i] === active_level[i]) begin
					run_r[i] <= run_r[i] + 16'h0001;
				end else begin
					if (run_r[i] != 16'h0000) begin
						last_r[i] <= run_r[i];
					end
					run_r[i] <= 16'h0000;
				end
			end
		end
	end

	// Widths of the last completed pulses
	assign width1 = last_r[0];
	assign width2 = last_r[1];
endmodule // pwm_load_model

// [tb.sv]
// Self-checking testbench for the three-channel PWM group.
// Assumes the design package is compiled first; inputs change at falling edges.
`timescale 1ns/10ps
module tb;
	import pwm_group_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic pwr = 1'b0;
	logic [2:0] st = 3'b000;
	logic [2:0] sp = 3'b000;
	logic [15:0] per = 16'h0009;
	logic [15:0] d1 = 16'h0003;
	logic [15:0] d2 = 16'h0005;
	logic [1:0] pol = 2'b00;
	logic [1:0] oe = 2'b11;
	logic vw = 1'b0;
	logic [1:0] vd = 2'b00;
	logic [2:0] en;
	logic [15:0] mc, c1, c2, w1, w2, sm, s1;
	logic irq, pm;
	logic [1:0] po;
	int n_mismatch = 0;
	int checks_done = 0;
	int n;

	// Clock at 50 MHz
	always #10 ref_clk = ~ref_clk;

	multi_pwm_channel_group multi_pwm_channel_group_inst (
		.ref_clk(ref_clk), .resetn(resetn), .timer_unit_power_enable(pwr),
		.master_start_trigger(st[0]), .slave1_start_trigger(st[1]),
		.slave2_start_trigger(st[2]), .master_stop_trigger(sp[0]),
		.slave1_stop_trigger(sp[1]), .slave2_stop_trigger(sp[2]),
		.master_period_value(per), .slave1_duty_value(d1), .slave2_duty_value(d2),
		.output_polarity_select(pol), .slave1_output_enable(oe[0]),
		.slave2_output_enable(oe[1]), .output_value_write(vw), .output_value_wdata(vd),
		.master_enable_status(en[0]), .slave1_enable_status(en[1]),
		.slave2_enable_status(en[2]), .master_down_counter(mc),
		.slave1_down_counter(c1), .slave2_down_counter(c2), .master_period_irq(irq),
		.slave1_pwm_output(po[0]), .slave2_pwm_output(po[1]), .pin_port_mode(pm)
	);

	pwm_load_model pwm_load_model_inst (
		.ref_clk(ref_clk), .resetn(resetn), .pins(po), .active_level(~pol),
		.width1(w1), .width2(w2)
	);

	// Compare helpers
	task automatic chk1(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask

	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic step(input int k);
		repeat (k) @(negedge ref_clk);
	endtask

	// One-cycle write of all three start or stop trigger bits together
	task automatic trig(input logic stop);
		if (stop) begin
			sp = 3'b111;
		end else begin
			st = 3'b111;
		end
		step(1);
		st = 3'b000;
		sp = 3'b000;
	endtask

	// Cycles until the next period event, bounded
	task automatic gap(output int k);
		k = 0;
		do begin
			step(1);
			k++;
		end while (irq !== 1'b1 && k < 100);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run of about 55 cycles
	initial begin
		#100000;
		n_mismatch++;
		end_of_test();
	end

	// Main sequence
	initial begin
		step(4);
		resetn = 1'b1;
		chk1("port mode", PORT_MODE_RESET, pm);
		chk16("master counter", CNT_RESET, mc);
		chk16("enables", 16'h0000, {13'h0000, en});
		pwr = 1'b1;
		step(1);
		chk1("port mode", 1'b0, pm);
		$display("test reset done");
		trig(1'b0);
		chk16("enables", 16'h0007, {13'h0000, en});
		chk1("start irq", 1'b1, irq);
		chk16("master load", per, mc);
		step(1);
		chk16("start one shot", per - 16'h0001, mc);
		chk1("irq pulse", 1'b0, irq);
		chk16("master step", per - 16'h0001, mc);
		chk16("slave1 load", d1, c1);
		chk16("slave2 load", d2, c2);
		chk1("slave1 active", 1'b1, po[0]);
		chk1("slave2 active", 1'b1, po[1]);
		step(1);
		chk16("slave1 count", d1 - 16'h0001, c1);
		gap(n);
		chk16("first period", per - 16'h0001, 16'(n));
		chk16("slave1 width", d1 + 16'h0001, w1);
		chk16("slave2 width", d2 + 16'h0001, w2);
		$display("test start done");
		per = 16'h0005;
		d1 = 16'h0000;
		d2 = 16'h0002;
		gap(n);
		chk16("old period", 16'h000A, 16'(n));
		gap(n);
		chk16("new period", 16'h0006, 16'(n));
		chk16("slave1 short width", 16'h0001, w1);
		chk16("slave2 width", 16'h0003, w2);
		$display("test update done");
		pol = 2'b10;
		d1 = 16'h0003;
		step(2);
		chk16("pins active", 16'h0001, {14'h0000, po});
		step(2);
		chk16("pins later", 16'h0003, {14'h0000, po});
		$display("test polarity done");
		sm = mc;
		s1 = c1;
		trig(1'b1);
		chk16("enables", 16'h0000, {13'h0000, en});
		chk16("master held", sm, mc);
		chk16("slave1 held", s1, c1);
		chk16("pins held", 16'h0003, {14'h0000, po});
		step(5);
		chk16("slave1 still", s1, c1);
		chk16("master still", sm, mc);
		chk1("no irq", 1'b0, irq);
		chk16("pins still", 16'h0003, {14'h0000, po});
		$display("test stop done");
		oe = 2'b00;
		vd = 2'b10;
		vw = 1'b1;
		step(1);
		vw = 1'b0;
		chk16("written pins", 16'h0002, {14'h0000, po});
		step(1);
		vd = 2'b01;
		vw = 1'b1;
		step(1);
		vw = 1'b0;
		chk16("rewritten pins", 16'h0001, {14'h0000, po});
		$display("test output value done");
		pwr = 1'b0;
		step(1);
		chk1("port mode", 1'b1, pm);
		chk16("master cleared", CNT_RESET, mc);
		chk16("pins cleared", 16'h0000, {14'h0000, po});
		pwr = 1'b1;
		step(1);
		$display("test power off done");
		oe = 2'b11;
		pol = 2'b00;
		trig(1'b0);
		chk1("restart irq", 1'b1, irq);
		step(1);
		chk16("pins restarted", 16'h0003, {14'h0000, po});
		gap(n);
		chk16("restart period", per, 16'(n));
		$display("test restart done");
		end_of_test();
	end
endmodule // tb
